// ===== tspf_pkg.sv
// Shared constants for the temperature source select and fan drive filter block.
package tspf_pkg;

    // Register offsets of the byte register port.
    localparam logic [7:0] TSPF_ADDR_SRC_SEL   = 8'h31;
    localparam logic [7:0] TSPF_ADDR_FILT_SET  = 8'h32;
    localparam logic [7:0] TSPF_ADDR_SHUT_THR  = 8'h33;
    localparam logic [7:0] TSPF_ADDR_Z3_LSB    = 8'h20;
    localparam logic [7:0] TSPF_ADDR_Z3_MIRROR = 8'h21;
    localparam logic [7:0] TSPF_ADDR_Z4_LSB    = 8'h22;
    localparam logic [7:0] TSPF_ADDR_Z4_MIRROR = 8'h23;
    localparam logic [7:0] TSPF_ADDR_Z3_TEMP   = 8'h52;
    localparam logic [7:0] TSPF_ADDR_Z4_TEMP   = 8'h53;

    // Reset values and writable masks of the three configuration bytes.
    localparam logic [7:0] TSPF_RST_BYTE       = 8'h00;
    localparam logic [7:0] TSPF_MASK_SRC_SEL   = 8'h1f;
    localparam logic [7:0] TSPF_MASK_FILT_SET  = 8'h77;
    localparam logic [7:0] TSPF_MASK_SHUT_THR  = 8'hf8;
    localparam logic [7:0] TSPF_RD_UNMAPPED    = 8'h00;

    // Field positions in the source select byte.
    localparam int TSPF_BIT_INTERNAL_SENSOR_DISABLE  = 0;
    localparam int TSPF_BIT_ADC_EXT  = 1;
    localparam int TSPF_BIT_Z1B_EN   = 2;
    localparam int TSPF_BIT_Z2B_EN   = 3;
    localparam int TSPF_BIT_INT_WR   = 4;

    // Field positions in the filter settings and threshold bytes.
    localparam int TSPF_COEF_W       = 3;
    localparam int TSPF_COEF1_LSB    = 0;
    localparam int TSPF_COEF2_LSB    = 4;
    localparam int TSPF_THR_LSB      = 3;
    localparam int TSPF_THR_W        = 5;
    localparam int TSPF_THR_SCALE_W  = 3;
    localparam logic [TSPF_COEF_W-1:0] TSPF_COEF_BYPASS = 3'h0;

    // Duty and filter widths.
    localparam int TSPF_DUTY_W       = 9;
    localparam int TSPF_FRAC_W       = 7;
    localparam int TSPF_TEMP_W       = 8;
    localparam int TSPF_NUM_DRIVES   = 2;

    // Filter update interval; with a shift of k the 95% settling takes
    // about 4.3, 10.4, 22.4, 46.4, 94, 190 and 382 updates for k = 1..7.
    localparam int TSPF_UPDATE_PERIOD_US = 22740;
    localparam int TSPF_CLK_MHZ          = 200;
    localparam int TSPF_UPDATE_CYCLES    = TSPF_UPDATE_PERIOD_US * TSPF_CLK_MHZ;
    localparam int TSPF_TICK_CNT_W       = 24;

endpackage // tspf_pkg

// ===== tspf_iir.sv
// First-order shift-and-add smoothing filter for one fan drive duty source.
`timescale 1ns/100ps
module tspf_iir #(
    parameter int DUTY_W = 9,
    parameter int FRAC_W = 7,
    parameter int COEF_W = 3
) (
    // Clock and reset.
    input  wire logic              clk_sys,
    input  wire logic              rst,
    // Control.
    input  wire logic              tick,
    input  wire logic [COEF_W-1:0] coef,
    // Data.
    input  wire logic [DUTY_W-1:0] duty_in,
    output logic      [DUTY_W-1:0] duty_out
);
    localparam int ACC_W = DUTY_W + FRAC_W;

    logic        [ACC_W-1:0] acc_r;
    logic        [ACC_W-1:0] acc_nxt;
    logic        [DUTY_W-1:0] out_r;
    logic        [DUTY_W-1:0] out_nxt;
    logic signed [ACC_W:0]   diff;
    logic signed [ACC_W:0]   step;
    logic signed [ACC_W:0]   sum;

    always_comb begin
        diff    = $signed({1'b0, duty_in, {FRAC_W{1'b0}}}) - $signed({1'b0, acc_r});
        step    = diff >>> coef;
        sum     = $signed({1'b0, acc_r}) + step;
        acc_nxt = acc_r;
        out_nxt = out_r;
        if (coef == '0) begin
            // Tracking the input while bypassed avoids a jump when filtering starts.
            acc_nxt = {duty_in, {FRAC_W{1'b0}}}; // [R10]
            out_nxt = duty_in; // [R10]
        end else begin
            if (tick) begin
                acc_nxt = sum[ACC_W-1:0]; // [R15]
            end
            out_nxt = acc_r[ACC_W-1:FRAC_W];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            acc_r <= '0;
            out_r <= '0;
        end else begin
            acc_r <= acc_nxt;
            out_r <= out_nxt;
        end
    end

    assign duty_out = out_r;

endmodule // tspf_iir

// ===== tspf_top.sv
// Temperature source selection, pin routing and fan drive smoothing with shutoff.
//
// How it works
// R1 - While the internal sensor disable bit is clear, die temperature results load zone 3.
// R2 - While the analog-to-external bit is set, zone 4 is read-only and loads channel 15 minus 128.
// R3 - While that bit is clear, zone 4 takes host writes and the host keeps it current.
// R4 - The zone 3 and zone 4 outputs to all consumers carry the register contents as selected.
// R5 - The zone 1 second diode bit routes its shared pin to the diode, else to analog input 1.
// R6 - The zone 2 second diode bit routes its shared pin to the diode, else to analog input 2.
// R7 - With the internal write enable bit set, zone 3 takes host writes and stops auto updates.
// R8 - Bits 2:0 of the filter byte pick the smoothing coefficient of drive 1.
// R9 - Bits 6:4 of the filter byte pick the smoothing coefficient of drive 2.
// R10 - Code zero bypasses the filter and codes one to seven give settling of 0.098 s to 8.686 s.
// R11 - The five-bit shutoff field times eight forms a nine-bit duty threshold.
// R12 - Drive 1 is forced off while its filtered duty is below the threshold.
// R13 - With the drive 1 filter bypassed the shutoff comparison is disabled.
// R14 - Reserved bits read as zero and ignore writes, and all three bytes reset to zero.
// R15 - Each filter is a first-order shift filter updated at a fixed internal tick.
`timescale 1ns/100ps
module tspf_top
    import tspf_pkg::*;
#(
    parameter int UPDATE_CYCLES = tspf_pkg::TSPF_UPDATE_CYCLES
) (
    // Clock and reset.
    input  wire logic                             clk_sys,
    input  wire logic                             rst,
    // Byte register port from the serial interface engine.
    input  wire logic [7:0]                       reg_addr,
    input  wire logic                             reg_wr,
    input  wire logic [7:0]                       reg_wdata,
    output logic      [7:0]                       reg_rdata,
    // Measurement results from the converter.
    input  wire logic                             die_temp_valid,
    input  wire logic [tspf_pkg::TSPF_TEMP_W-1:0] die_temp,
    input  wire logic                             analog_channel_15_valid,
    input  wire logic [tspf_pkg::TSPF_TEMP_W-1:0] analog_channel_15,
    // Zone temperatures for the fan control consumers.
    output logic      [tspf_pkg::TSPF_TEMP_W-1:0] zone3_temp,
    output logic      [tspf_pkg::TSPF_TEMP_W-1:0] zone4_temp,
    // Shared pin routing to the analog front end.
    output logic                                  zone1_second_diode_enable,
    output logic                                  zone2_second_diode_enable,
    // Duty sources and smoothed duties.
    input  wire logic [tspf_pkg::TSPF_DUTY_W-1:0] fan_drive_output_1_src,
    input  wire logic [tspf_pkg::TSPF_DUTY_W-1:0] fan_drive_output_2_src,
    output logic      [tspf_pkg::TSPF_DUTY_W-1:0] fan_drive_output_1,
    output logic      [tspf_pkg::TSPF_DUTY_W-1:0] fan_drive_output_2
);

    // Configuration bytes.
    logic [7:0]             src_sel_r;
    logic [7:0]             src_sel_nxt;
    logic [7:0]             filt_set_r;
    logic [7:0]             filt_set_nxt;
    logic [7:0]             shut_thr_r;
    logic [7:0]             shut_thr_nxt;

    // Zone temperature registers.
    logic [TSPF_TEMP_W-1:0] zone3_r;
    logic [TSPF_TEMP_W-1:0] zone3_nxt;
    logic [TSPF_TEMP_W-1:0] zone4_r;
    logic [TSPF_TEMP_W-1:0] zone4_nxt;

    // Read data.
    logic [7:0]             rdata_r;
    logic [7:0]             rdata_nxt;

    // Filter update tick.
    logic [TSPF_TICK_CNT_W-1:0] tick_cnt_r;
    logic [TSPF_TICK_CNT_W-1:0] tick_cnt_nxt;
    logic                       tick_r;
    logic                       tick_nxt;

    // Filter channels and the drive outputs.
    logic [TSPF_DUTY_W-1:0] duty_src  [TSPF_NUM_DRIVES];
    logic [TSPF_DUTY_W-1:0] duty_filt [TSPF_NUM_DRIVES];
    logic [TSPF_COEF_W-1:0] coef      [TSPF_NUM_DRIVES];
    logic [TSPF_DUTY_W-1:0] drive1_r;
    logic [TSPF_DUTY_W-1:0] drive1_nxt;
    logic [TSPF_DUTY_W-1:0] drive2_r;
    logic [TSPF_DUTY_W-1:0] drive2_nxt;
    logic [TSPF_DUTY_W-1:0] drive1_shutoff_threshold;

    // Decoded fields.
    logic internal_sensor_disable;
    logic adc_to_external_temp;
    logic internal_temp_write_enable;
    logic [TSPF_COEF_W-1:0] drive1_filter_coefficient;
    logic [TSPF_COEF_W-1:0] drive2_filter_coefficient;
    logic [TSPF_THR_W-1:0]  drive1_shutoff_field;

    // Address decode shared by the write and read paths.
    logic                   hit_src_sel;
    logic                   hit_filt_set;
    logic                   hit_shut_thr;
    logic                   hit_zone3;
    logic                   hit_zone4;

    // Zone update permissions and the drive 1 shutoff decision.
    logic                   zone3_host_wr;
    logic                   zone3_auto_ld;
    logic                   zone4_host_wr;
    logic                   zone4_auto_ld;
    logic                   drive1_shutoff_active;

    assign internal_sensor_disable    = src_sel_r[TSPF_BIT_INTERNAL_SENSOR_DISABLE];
    assign adc_to_external_temp       = src_sel_r[TSPF_BIT_ADC_EXT];
    assign internal_temp_write_enable = src_sel_r[TSPF_BIT_INT_WR];
    assign drive1_filter_coefficient  = filt_set_r[TSPF_COEF1_LSB +: TSPF_COEF_W]; // [R8]
    assign drive2_filter_coefficient  = filt_set_r[TSPF_COEF2_LSB +: TSPF_COEF_W]; // [R9]
    assign drive1_shutoff_field       = shut_thr_r[TSPF_THR_LSB +: TSPF_THR_W];
    assign drive1_shutoff_threshold   = {1'b0, drive1_shutoff_field, {TSPF_THR_SCALE_W{1'b0}}}; // [R11]

    // A zone answers at its own address and at its mirror, so one decode serves
    // both the write and the read path and the two cannot drift apart.
    always_comb begin
        hit_src_sel  = 1'b0;
        hit_filt_set = 1'b0;
        hit_shut_thr = 1'b0;
        hit_zone3    = 1'b0;
        hit_zone4    = 1'b0;
        if (reg_addr == TSPF_ADDR_SRC_SEL) begin
            hit_src_sel = 1'b1;
        end else if (reg_addr == TSPF_ADDR_FILT_SET) begin
            hit_filt_set = 1'b1;
        end else if (reg_addr == TSPF_ADDR_SHUT_THR) begin
            hit_shut_thr = 1'b1;
        end else if (reg_addr == TSPF_ADDR_Z3_TEMP || reg_addr == TSPF_ADDR_Z3_MIRROR) begin
            hit_zone3 = 1'b1;
        end else if (reg_addr == TSPF_ADDR_Z4_TEMP || reg_addr == TSPF_ADDR_Z4_MIRROR) begin
            hit_zone4 = 1'b1;
        end
    end

    // Configuration byte writes.
    // Reserved bits are dropped on the way in, so the read path needs no masks.
    always_comb begin
        src_sel_nxt  = src_sel_r;
        filt_set_nxt = filt_set_r;
        shut_thr_nxt = shut_thr_r;
        if (reg_wr) begin
            if (hit_src_sel) begin
                src_sel_nxt = reg_wdata & TSPF_MASK_SRC_SEL; // [R14]
            end else if (hit_filt_set) begin
                filt_set_nxt = reg_wdata & TSPF_MASK_FILT_SET; // [R14]
            end else if (hit_shut_thr) begin
                shut_thr_nxt = reg_wdata & TSPF_MASK_SHUT_THR; // [R14]
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            src_sel_r  <= TSPF_RST_BYTE; // [R14]
            filt_set_r <= TSPF_RST_BYTE; // [R14]
            shut_thr_r <= TSPF_RST_BYTE; // [R14]
        end else begin
            src_sel_r  <= src_sel_nxt;
            filt_set_r <= filt_set_nxt;
            shut_thr_r <= shut_thr_nxt;
        end
    end

    // Zone temperature sources. A host write and a measurement in the same cycle
    // cannot meet, since each mode admits only one of the two sources.
    // With both paths shut, zone 3 holds its last value and consumers may see it go stale.
    assign zone3_host_wr = reg_wr && hit_zone3 && internal_temp_write_enable; // [R7]
    assign zone3_auto_ld = die_temp_valid && !internal_sensor_disable
                           && !internal_temp_write_enable; // [R1]
    assign zone4_host_wr = reg_wr && hit_zone4 && !adc_to_external_temp; // [R3]
    assign zone4_auto_ld = analog_channel_15_valid && adc_to_external_temp; // [R2]

    always_comb begin
        zone3_nxt = zone3_r;
        if (zone3_host_wr) begin
            zone3_nxt = reg_wdata; // [R7]
        end else if (zone3_auto_ld) begin
            zone3_nxt = die_temp; // [R1]
        end
        zone4_nxt = zone4_r;
        if (zone4_auto_ld) begin
            // Inverting the top bit turns the offset reading into a signed value.
            zone4_nxt = {~analog_channel_15[TSPF_TEMP_W-1],
                         analog_channel_15[TSPF_TEMP_W-2:0]}; // [R2]
        end else if (zone4_host_wr) begin
            zone4_nxt = reg_wdata; // [R3]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            zone3_r <= '0;
            zone4_r <= '0;
        end else begin
            zone3_r <= zone3_nxt;
            zone4_r <= zone4_nxt;
        end
    end

    // Registered read data, one cycle behind the address.
    always_comb begin
        if (hit_src_sel) begin
            rdata_nxt = src_sel_r;
        end else if (hit_filt_set) begin
            rdata_nxt = filt_set_r;
        end else if (hit_shut_thr) begin
            rdata_nxt = shut_thr_r;
        end else if (hit_zone3) begin
            rdata_nxt = zone3_r;
        end else if (hit_zone4) begin
            rdata_nxt = zone4_r;
        end else begin
            // The half-degree bytes hold no fraction here and read as zero too.
            rdata_nxt = TSPF_RD_UNMAPPED;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_r <= TSPF_RD_UNMAPPED;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Fixed-rate update tick shared by both filters.
    // The counter restarts with reset, so the first update lands one full period later.
    always_comb begin
        tick_nxt     = 1'b0;
        tick_cnt_nxt = tick_cnt_r + TSPF_TICK_CNT_W'(1'b1);
        if (tick_cnt_r >= TSPF_TICK_CNT_W'(UPDATE_CYCLES - 1)) begin
            tick_cnt_nxt = '0;
            tick_nxt     = 1'b1; // [R15]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tick_cnt_r <= '0;
            tick_r     <= 1'b0;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
            tick_r     <= tick_nxt;
        end
    end

    // Smoothing filters, one per drive.
    // Both filters share one tick, so equal codes settle in step.
    assign duty_src[0] = fan_drive_output_1_src;
    assign duty_src[1] = fan_drive_output_2_src;
    assign coef[0]     = drive1_filter_coefficient;
    assign coef[1]     = drive2_filter_coefficient;

    for (genvar ch = 0; ch < TSPF_NUM_DRIVES; ch++) begin : g_filt
        tspf_iir #(
            .DUTY_W (TSPF_DUTY_W),
            .FRAC_W (TSPF_FRAC_W),
            .COEF_W (TSPF_COEF_W)
        ) u_iir (
            .clk_sys  (clk_sys),
            .rst      (rst),
            .tick     (tick_r),
            .coef     (coef[ch]), // [R8] [R9] [R10]
            .duty_in  (duty_src[ch]),
            .duty_out (duty_filt[ch])
        );
    end

    // Drive outputs with the drive 1 low-duty shutoff. Drive 2 has no shutoff in this
    // block, so its smoothed duty passes straight to the output flop.
    assign drive1_shutoff_active = drive1_filter_coefficient != TSPF_COEF_BYPASS // [R13]
                                   && duty_filt[0] < drive1_shutoff_threshold; // [R11]

    always_comb begin
        drive1_nxt = duty_filt[0];
        if (drive1_shutoff_active) begin
            drive1_nxt = '0; // [R12]
        end
        drive2_nxt = duty_filt[1];
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            drive1_r <= '0;
            drive2_r <= '0;
        end else begin
            drive1_r <= drive1_nxt;
            drive2_r <= drive2_nxt;
        end
    end

    // Outputs, all straight from flip-flops.
    assign reg_rdata                 = rdata_r;
    assign zone3_temp                = zone3_r; // [R4]
    assign zone4_temp                = zone4_r; // [R4]
    assign zone1_second_diode_enable = src_sel_r[TSPF_BIT_Z1B_EN]; // [R5]
    assign zone2_second_diode_enable = src_sel_r[TSPF_BIT_Z2B_EN]; // [R6]
    assign fan_drive_output_1        = drive1_r;
    assign fan_drive_output_2        = drive2_r;

endmodule // tspf_top

// ===== tspf_top_assertions.sv
// Concurrent checks on the ports of the temperature source and drive filter block.
`timescale 1ns/100ps
module tspf_top_assertions
    import tspf_pkg::*;
(
    // Clock and reset.
    input wire logic       clk_sys,
    input wire logic       rst,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Measurements and zones.
    input wire logic       die_temp_valid,
    input wire logic [7:0] die_temp,
    input wire logic       analog_channel_15_valid,
    input wire logic [7:0] analog_channel_15,
    input wire logic [7:0] zone3_temp,
    input wire logic [7:0] zone4_temp,
    input wire logic       zone1_second_diode_enable,
    input wire logic       zone2_second_diode_enable,
    // Duties.
    input wire logic [8:0] fan_drive_output_1_src,
    input wire logic [8:0] fan_drive_output_2_src,
    input wire logic [8:0] fan_drive_output_1,
    input wire logic [8:0] fan_drive_output_2
);
    logic [7:0] sel_r, filt_r, thr_r, exp_rd;
    logic [1:0] quiet_r;
    logic       z3_wr, z4_wr;
    assign z3_wr = reg_wr && (reg_addr == 8'h52 || reg_addr == 8'h21);
    assign z4_wr = reg_wr && (reg_addr == 8'h53 || reg_addr == 8'h23);
    // Shadow copies of the configuration bytes, kept from the write strobes.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sel_r <= 8'h00;
            filt_r <= 8'h00;
            thr_r <= 8'h00;
            quiet_r <= 2'h0;
        end else begin
            if (reg_wr && reg_addr == 8'h31) sel_r <= reg_wdata & 8'h1f;
            if (reg_wr && reg_addr == 8'h32) filt_r <= reg_wdata & 8'h77;
            if (reg_wr && reg_addr == 8'h33) thr_r <= reg_wdata & 8'hf8;
            // Settling guard: duty checks wait three cycles after any filter change.
            if (reg_wr && (reg_addr == 8'h32 || reg_addr == 8'h33)) quiet_r <= 2'h0;
            else if (quiet_r != 2'h3) quiet_r <= quiet_r + 2'h1;
        end
    end
    always_comb begin
        case (reg_addr)
            8'h31: exp_rd = sel_r;
            8'h32: exp_rd = filt_r;
            8'h33: exp_rd = thr_r;
            8'h52, 8'h21: exp_rd = zone3_temp;
            8'h53, 8'h23: exp_rd = zone4_temp;
            default: exp_rd = 8'h00;
        endcase
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    AST_RD_DATA: assert property (!$past(rst) |-> reg_rdata == $past(exp_rd))
        else $error("read data differs from register contents");
    AST_ZONE3_AUTO: assert property (die_temp_valid && !sel_r[0] && !sel_r[4]
        |=> zone3_temp == $past(die_temp)) else $error("zone 3 missed die reading");
    AST_ZONE3_FROZEN: assert property ((sel_r[0] || sel_r[4]) && !reg_wr
        |=> $stable(zone3_temp)) else $error("zone 3 changed while frozen");
    AST_ZONE3_WR: assert property (z3_wr && sel_r[4] |=> zone3_temp == $past(reg_wdata))
        else $error("zone 3 write lost");
    AST_ZONE4_ADC: assert property (analog_channel_15_valid && sel_r[1] |=>
        zone4_temp == ($past(analog_channel_15) ^ 8'h80)) else $error("zone 4 offset wrong");
    AST_ZONE4_RO: assert property (sel_r[1] && !analog_channel_15_valid
        |=> $stable(zone4_temp)) else $error("zone 4 changed while read-only");
    AST_ZONE4_WR: assert property (z4_wr && !sel_r[1] |=> zone4_temp == $past(reg_wdata))
        else $error("zone 4 write lost");
    AST_PIN_ROUTE: assert property ({zone2_second_diode_enable,
        zone1_second_diode_enable} == sel_r[3:2]) else $error("pin routing wrong");
    AST_BYPASS1: assert property (quiet_r == 2'h3 && filt_r[2:0] == 3'h0
        |-> fan_drive_output_1 == $past(fan_drive_output_1_src, 2)) else $error("drive 1 bypass");
    AST_BYPASS2: assert property (quiet_r == 2'h3 && filt_r[6:4] == 3'h0
        |-> fan_drive_output_2 == $past(fan_drive_output_2_src, 2)) else $error("drive 2 bypass");
    AST_SHUTOFF: assert property (quiet_r == 2'h3 && filt_r[2:0] != 3'h0
        && fan_drive_output_1 != 9'h000 && $stable(fan_drive_output_1)
        |-> fan_drive_output_1 >= {1'b0, thr_r[7:3], 3'h0}) else $error("drive 1 not shut off");
    CV_ADC: cover property (analog_channel_15_valid && sel_r[1]);
    CV_ZONE3_WR: cover property (z3_wr && sel_r[4]);
    CV_SHUT: cover property (filt_r[2:0] != 3'h0 && thr_r != 8'h00 && fan_drive_output_1 == 9'h000);
endmodule // tspf_top_assertions
bind tspf_top tspf_top_assertions i_chk (.*);

// ===== tspf_host_model.sv
// Byte register master standing in for the serial host of the block.
`timescale 1ns/100ps
module tspf_host_model (
    // Clock.
    input  wire logic       clk_sys,
    // Byte register port.
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
    end
    // Zone 4 is kept current only through these writes while it is writable.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_wr = 1'b0;
        // Stale data is inverted so a late capture cannot pass by luck.
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        #1;
        reg_addr = a;
        @(posedge clk_sys);
        #1;
        d = reg_rdata;
    endtask
endmodule // tspf_host_model

// ===== test_tspf_top.sv
// Self-checking testbench of the temperature source and drive filter block.
`timescale 1ns/100ps
module test_tspf_top;
    import tspf_pkg::*;
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, zone3_temp, zone4_temp, rd;
    logic [7:0] die_temp = 8'h00;
    logic [7:0] ch15 = 8'h00;
    logic       reg_wr, z1_en, z2_en;
    logic       die_valid = 1'b0;
    logic       ch15_valid = 1'b0;
    logic [8:0] src1 = 9'h000;
    logic [8:0] src2 = 9'h000;
    logic [8:0] out1, out2;
    int         failures = 0;
    int         n_checks = 0;
    // Address, written byte, expected read back.
    logic [23:0] rows [5] = '{24'h31ff1f, 24'h32ff77, 24'h33fff8, 24'h40ff00, 24'h20ab00};
    tspf_top #(.UPDATE_CYCLES(8)) i_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .die_temp_valid(die_valid), .die_temp(die_temp), .analog_channel_15_valid(ch15_valid),
        .analog_channel_15(ch15), .zone3_temp(zone3_temp), .zone4_temp(zone4_temp),
        .zone1_second_diode_enable(z1_en), .zone2_second_diode_enable(z2_en),
        .fan_drive_output_1_src(src1), .fan_drive_output_2_src(src2),
        .fan_drive_output_1(out1), .fan_drive_output_2(out2));
    tspf_host_model i_host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (failures == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic meas(input logic adc, input logic [7:0] v);
        @(posedge clk_sys);
        #1;
        ch15 = v;
        die_temp = v;
        ch15_valid = adc;
        die_valid = !adc;
        @(posedge clk_sys);
        #1;
        ch15_valid = 1'b0;
        die_valid = 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        i_host.rd(a, rd);
        chk({1'b0, rd}, {1'b0, exp});
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        #(20000 * 5);
        failures++;
        finish_test();
    end
    initial begin
        wait_cyc(10);
        rst = 1'b0;
        rdchk(8'h31, 8'h00);
        foreach (rows[i]) begin
            i_host.wr(rows[i][23:16], rows[i][15:8]);
            rdchk(rows[i][23:16], rows[i][7:0]);
        end
        i_host.wr(8'h31, 8'h04);
        chk({7'h0, z2_en, z1_en}, 9'h001);
        i_host.wr(8'h31, 8'h08);
        chk({7'h0, z2_en, z1_en}, 9'h002);
        i_host.wr(8'h31, 8'h00);
        meas(1'b0, 8'h35);
        chk({1'b0, zone3_temp}, 9'h035);
        i_host.wr(8'h31, 8'h01);
        meas(1'b0, 8'h44);
        chk({1'b0, zone3_temp}, 9'h035);
        i_host.wr(8'h31, 8'h10);
        i_host.wr(8'h52, 8'h66);
        meas(1'b0, 8'h44);
        chk({1'b0, zone3_temp}, 9'h066);
        i_host.wr(8'h21, 8'h67);
        rdchk(8'h52, 8'h67);
        i_host.wr(8'h31, 8'h02);
        meas(1'b1, 8'h90);
        chk({1'b0, zone4_temp}, 9'h010);
        i_host.wr(8'h53, 8'h55);
        rdchk(8'h23, 8'h10);
        i_host.wr(8'h31, 8'h00);
        i_host.wr(8'h53, 8'h22);
        meas(1'b1, 8'h91);
        chk({1'b0, zone4_temp}, 9'h022);
        // Bypass with a high threshold must pass a low duty untouched.
        i_host.wr(8'h32, 8'h00);
        src1 = 9'h050;
        src2 = 9'h1ab;
        wait_cyc(3);
        chk(out1, 9'h050);
        chk(out2, 9'h1ab);
        src1 = 9'h000;
        src2 = 9'h000;
        wait_cyc(3);
        i_host.wr(8'h33, 8'h00);
        i_host.wr(8'h32, 8'h71);
        src1 = 9'h100;
        src2 = 9'h100;
        wait_cyc(20);
        chk({8'h0, out1 >= 9'h080}, 9'h001);
        chk({8'h0, out2 < 9'h010}, 9'h001);
        wait_cyc(300);
        chk({8'h0, out1 >= 9'h0ff}, 9'h001);
        chk({8'h0, out2 > 9'h030 && out2 < 9'h060}, 9'h001);
        src1 = 9'h0f0;
        i_host.wr(8'h33, 8'hf8);
        wait_cyc(300);
        chk(out1, 9'h000);
        i_host.wr(8'h33, 8'he8);
        wait_cyc(5);
        chk({8'h0, out1 >= 9'h0e8}, 9'h001);
        rst = 1'b1;
        wait_cyc(3);
        rst = 1'b0;
        chk({7'h0, z2_en, z1_en}, 9'h000);
        chk({1'b0, zone3_temp}, 9'h000);
        rdchk(8'h32, 8'h00);
        rdchk(8'h33, 8'h00);
        // Code 3 crosses 95% of a step after 22 to 23 updates, code 2 after about 10.
        src1 = 9'h000;
        src2 = 9'h000;
        i_host.wr(8'h32, 8'h23);
        src1 = 9'h100;
        src2 = 9'h100;
        wait_cyc(150);
        chk({8'h0, out1 < 9'h0f3}, 9'h001);
        chk({8'h0, out2 >= 9'h0f3}, 9'h001);
        wait_cyc(60);
        chk({8'h0, out1 >= 9'h0f3}, 9'h001);
        finish_test();
    end
endmodule // test_tspf_top
